// >>> common/sbs_pkg.sv
// Constants for the synchronous burst SRAM control block.
// What this block does
// - Chip enable high with controller strobe low deselects; data lines go undriven, one cycle later with dual deselect.
// - Processor strobe low, or controller strobe low without write, starts read burst.
// - Controller strobe low with write decode starts write burst at external address.
// - Controller strobe high, advance low, continues burst at next counter address.
// - Same strobes with advance high suspends burst and repeats current address.
// - Global write writes all lanes; byte write writes enabled lanes; else read.
// - Read cycles drive every byte lane regardless of lane write enables.
// - Write cycles keep every data pin undriven.
// - Lanes c and d exist only in the wide configuration.
// - Output enable high turns data drivers off at once, without the clock.
// - Output enable low only passes drivers a read already turned on.
// - A read with output enable high still advances the burst counter.
// - Order select picks linear or interleaved four-beat order, wrapping after four.
// - Deselect latency select low gives dual, high gives single cycle deselect.
// - Sleep request high puts the device in standby; low keeps it active.
// - Parity lane enable low uses the ninth bit of each lane.
package sbs_pkg;
   localparam int ADDR_W = 18;
   localparam int LANE_W = 9;
   localparam int LANE_CNT = 4;
   localparam int DATA_W = LANE_W * LANE_CNT;
   localparam int APB_AW = 12;
   // Register offsets.
   localparam logic [APB_AW-1:0] OFS_MODE = 12'h000;
   localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
   // Mode register fields and reset values.
   localparam int MODE_ORDER_BIT = 0;
   localparam int MODE_DESEL_BIT = 1;
   localparam int MODE_SLEEP_BIT = 2;
   localparam int MODE_PARITY_BIT = 3;
   localparam logic [3:0] MODE_RESET = 4'h2;
   // Status register fields.
   localparam int STAT_ADDR_LSB = 0;
   localparam int STAT_ACTIVE_BIT = 18;
   localparam int STAT_WRITE_BIT = 19;
   localparam int STAT_DRIVE_BIT = 20;
   localparam int STAT_SLEEP_BIT = 21;
   localparam int SYNC_W = 7 + LANE_CNT + ADDR_W + DATA_W;
   typedef enum logic [2:0] {
      SBS_OP_IDLE, SBS_OP_DESEL, SBS_OP_READ, SBS_OP_WRITE
   } sbs_op_t;
endpackage : sbs_pkg

// >>> sim/sbs_bus_master.sv
// Bus master model driving the burst SRAM pins.
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_master
   import sbs_pkg::*;
(
   // Clock.
   input  wire logic              pclk,
   // Pins: enable, strobes, step, writes, output enable; lanes, address, data.
   output logic [6:0]             ctl,
   output logic [3:0]             lane_n,
   output logic [ADDR_W-1:0]      addr,
   output logic [DATA_W-1:0]      dq
);
   initial begin
      ctl = 7'h7f;
      lane_n = 4'hf;
      addr = '0;
      dq = '0;
   end
   // A released data bus shows the inverse of its last value.
   task automatic drive(input logic [6:0] c, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [3:0] ln);
      logic wr;
      wr = c[5] && (!c[2] || (!c[1] && ln != 4'hf));
      @(posedge pclk);
      ctl <= {c[6:1], c[0] | wr};
      lane_n <= ln;
      addr <= a;
      dq <= wr ? d : ~dq;
   endtask : drive
endmodule : sbs_bus_master
`default_nettype wire

// >>> sim/sbs_ctrl_props.sv
// Concurrent checks on the burst SRAM control ports.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_props
   import sbs_pkg::*;
(
   // APB side.
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // SRAM pins.
   input wire logic              chip_enable_n,
   input wire logic              proc_addr_strobe_n,
   input wire logic              ctrl_addr_strobe_n,
   input wire logic              global_write_n,
   input wire logic              byte_write_n,
   input wire logic              output_en_n,
   input wire logic [DATA_W-1:0] dq_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] mode_q;
   logic       acc, desel, rd_p, rd_c, wr_c;
   assign acc = psel && penable;
   assign desel = chip_enable_n && !ctrl_addr_strobe_n;
   assign rd_p = !chip_enable_n && !proc_addr_strobe_n;
   assign rd_c = !chip_enable_n && proc_addr_strobe_n && !ctrl_addr_strobe_n
                 && global_write_n && byte_write_n;
   assign wr_c = !chip_enable_n && proc_addr_strobe_n && !ctrl_addr_strobe_n && !global_write_n;
   // Shadow of the mode register, so read masks follow the parity setting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_RESET;
      end else if (acc && pready && pwrite && paddr == OFS_MODE) begin
         mode_q <= pwdata[3:0];
      end
   end
   chk_oe_gate: assert property (output_en_n |-> dq_oe == '0)
      else $error("data drivers on while output enable is high");
   chk_apb_ready: assert property (acc |-> pready)
      else $error("access phase without ready");
   chk_apb_refuse: assert property (acc && paddr != OFS_MODE && paddr != OFS_STATUS
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_prdata_idle: assert property (!acc |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error outside access phase");
   chk_mode_read: assert property (acc && !pwrite && paddr == OFS_MODE
      |-> prdata == {28'h0, mode_q})
      else $error("mode register reads back wrong");
   chk_desel_off: assert property (desel [*5] |=> dq_oe == '0)
      else $error("drivers still on after deselect");
   chk_write_hiz: assert property (wr_c |-> ##3 dq_oe == '0)
      else $error("drivers on after write decode");
   chk_read_drive: assert property ((rd_p || rd_c) && !mode_q[2] ##3 !output_en_n
      |-> dq_oe == (mode_q[3] ? ~36'h804020100 : '1))
      else $error("read does not drive every lane");
   cov_read: cover property (rd_p ##3 !output_en_n);
   cov_write: cover property (wr_c);
   cov_desel: cover property (desel [*5]);
endmodule : sbs_ctrl_props

bind sbs_ctrl sbs_ctrl_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
   .pwdata, .prdata, .pready, .pslverr, .chip_enable_n, .proc_addr_strobe_n,
   .ctrl_addr_strobe_n, .global_write_n, .byte_write_n, .output_en_n, .dq_oe);
`default_nettype wire

// >>> sim/tb_sync_burst_sram_control.sv
// Self-checking bench for the burst SRAM control block.
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_control
   import sbs_pkg::*;
;
   localparam logic [DATA_W-1:0] PAR = 36'h804020100;
   logic              pclk = 1'b0, presetn = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [31:0]       pwdata = '0, prdata, r;
   logic [6:0]        ctl;
   logic [3:0]        lane_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq, dq_out, dq_oe;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   int                errors = 0, n_compared = 0, cycles = 0;

   initial forever #2.5 pclk = ~pclk;
   sbs_bus_master master (.pclk, .ctl, .lane_n, .addr, .dq);
   sbs_ctrl DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .chip_enable_n(ctl[6]), .proc_addr_strobe_n(ctl[5]),
      .ctrl_addr_strobe_n(ctl[4]), .burst_step_n(ctl[3]), .global_write_n(ctl[2]),
      .byte_write_n(ctl[1]), .lane_a_write_en_n(lane_n[0]), .lane_b_write_en_n(lane_n[1]),
      .lane_c_write_en_n(lane_n[2]), .lane_d_write_en_n(lane_n[3]), .output_en_n(ctl[0]),
      .addr, .dq_in(dq), .dq_out, .dq_oe);

   always @(posedge pclk) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         report_and_stop();
      end
   end
   // ====================
   // Helpers
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] b, input int i,
                                                input logic il);
      logic [1:0] k;
      k = i[1:0];
      return {b[ADDR_W-1:2], il ? b[1:0] ^ k : b[1:0] + k};
   endfunction : baddr
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, d,
                                                input logic [3:0] ln, input logic po);
      for (int k = 0; k < LANE_CNT; k++)
         if (!ln[k]) o[k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
      return po ? o & ~PAR : o;
   endfunction : merge
   function automatic logic [DATA_W-1:0] oem(input logic po, oe_n);
      return oe_n ? '0 : po ? ~PAR : '1;
   endfunction : oem
   // One cycle, two suspend reads, then a look once the first cycle is decoded.
   task automatic beat(input logic [6:0] c, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [3:0] ln,
                       input logic [DATA_W-1:0] eo, input logic co,
                       input logic [DATA_W-1:0] ed);
      master.drive(c, a, d, ln);
      repeat (2) master.drive({6'h3f, c[0]}, a, d, 4'hf);
      @(posedge pclk);
      #1;
      chk("output enables", dq_oe, eo);
      if (co) chk("read data", dq_out, ed);
   endtask : beat
   // ====================
   // Main sequence
   initial begin
      logic [3:0]        mo, ln;
      logic [ADDR_W-1:0] b, a;
      logic [DATA_W-1:0] d;
      logic [6:0]        c;
      void'($urandom(93));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode reset", 36'(r), 36'(MODE_RESET));
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped error", 36'(e), 36'h1);
      for (int v = 0; v < 8; v++) begin
         mo = {v[2], 1'b0, v[1], v[0]};
         apb(1'b1, OFS_MODE, 32'(mo));
         b = ADDR_W'($urandom);
         for (int i = 0; i < 4; i++) begin
            d = {4'($urandom), $urandom};
            a = baddr(b, i, mo[0]);
            mem[a] = merge(d, d, 4'h0, mo[3]);
            c = (i == 0 ? 7'h29 : {1'($urandom), 6'h31}) | {5'h0, 1'($urandom), 1'b0};
            beat(c, i ? ~a : a, d, 4'($urandom), '0, 1'b0, '0);
         end
         a = baddr(b, $urandom_range(3), mo[0]);
         ln = 4'($urandom_range(14));
         d = {4'($urandom), $urandom};
         mem[a] = merge(mem[a], d, ln, mo[3]);
         beat(7'h2d, a, d, ln, '0, 1'b0, '0);
         for (int i = 0; i < 5; i++) begin
            c = {1'($urandom), 5'h1b, 1'(i < 2)};
            if (i == 0) c = v[0] ? 7'h2f : {2'b00, 4'($urandom), 1'b1};
            beat(c, i ? ~b : b, d, 4'($urandom), oem(mo[3], c[0]), 1'b1,
                 mem[baddr(b, i, mo[0])]);
         end
         repeat (3) master.drive(7'h46, b, d, 4'hf);
         @(posedge pclk);
         #1;
         chk("deselect hold", dq_oe, mo[1] ? '0 : oem(mo[3], 1'b0));
         @(posedge pclk);
         #1;
         chk("deselect off", dq_oe, '0);
         apb(1'b0, OFS_STATUS, 32'h0);
         chk("status flags", 36'(r[21:18]), 36'h0);
      end
      apb(1'b1, OFS_MODE, 32'h6);
      beat(7'h0e, b, d, 4'hf, '0, 1'b0, '0);
      apb(1'b1, OFS_MODE, 32'h2);
      beat(7'h0e, b, d, 4'hf, '1, 1'b1, mem[b]);
      report_and_stop();
   end
endmodule : tb_sync_burst_sram_control
`default_nettype wire

// >>> verilog/sbs_ctrl.sv
// Synchronous burst SRAM control with memory array and APB mode and status registers.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl
   import sbs_pkg::*;
(
   // APB clock, reset and slave port.
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // SRAM control pins.
   input  wire logic              chip_enable_n,
   input  wire logic              proc_addr_strobe_n,
   input  wire logic              ctrl_addr_strobe_n,
   input  wire logic              burst_step_n,
   input  wire logic              global_write_n,
   input  wire logic              byte_write_n,
   input  wire logic              lane_a_write_en_n,
   input  wire logic              lane_b_write_en_n,
   input  wire logic              lane_c_write_en_n,
   input  wire logic              lane_d_write_en_n,
   input  wire logic              output_en_n,
   // SRAM address and data pins.
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0]      dq_out,
   output logic [DATA_W-1:0]      dq_oe
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [LANE_CNT-1:0] lane_pin_n;

   assign lane_pin_n = {lane_d_write_en_n, lane_c_write_en_n,
                        lane_b_write_en_n, lane_a_write_en_n};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= {chip_enable_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
                       burst_step_n, global_write_n, byte_write_n,
                       1'b0, lane_pin_n, addr, dq_in};
         sync2_reg <= sync1_reg;
      end
   end

   logic                ce_n;
   logic                proc_addr_strobe_n_n;
   logic                ctrl_addr_strobe_n_n;
   logic                step_n;
   logic                gw_n;
   logic                bw_n;
   logic [LANE_CNT-1:0] lane_n;
   logic [ADDR_W-1:0]   ext_addr;
   logic [DATA_W-1:0]   din;

   assign ce_n     = sync2_reg[SYNC_W-1];
   assign proc_addr_strobe_n_n   = sync2_reg[SYNC_W-2];
   assign ctrl_addr_strobe_n_n   = sync2_reg[SYNC_W-3];
   assign step_n   = sync2_reg[SYNC_W-4];
   assign gw_n     = sync2_reg[SYNC_W-5];
   assign bw_n     = sync2_reg[SYNC_W-6];
   assign lane_n   = sync2_reg[ADDR_W+DATA_W +: LANE_CNT];
   assign ext_addr = sync2_reg[DATA_W +: ADDR_W];
   assign din      = sync2_reg[DATA_W-1:0];

   // ==========================================================
   // Mode register
   // ==========================================================
   logic [3:0] mode_reg;
   logic       order_il;
   logic       single_desel;
   logic       sleep_req;
   logic       parity_lane_en_n;

   assign order_il         = mode_reg[MODE_ORDER_BIT];
   assign single_desel     = mode_reg[MODE_DESEL_BIT];
   assign sleep_req        = mode_reg[MODE_SLEEP_BIT];
   assign parity_lane_en_n = mode_reg[MODE_PARITY_BIT];

   logic wr_take;

   assign wr_take = psel && penable && pwrite && (paddr == OFS_MODE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_RESET;
      end else if (wr_take) begin
         mode_reg <= pwdata[3:0];
      end
   end

   // ==========================================================
   // Cycle decode
   // ==========================================================
   logic [LANE_CNT-1:0] lane_mask;
   logic                wr_req;
   logic                start_rd;
   logic                start_wr;
   logic                desel;
   logic                cont;
   sbs_op_t             op;

   always_comb begin
      if (!gw_n) begin
         lane_mask = '1;
      end else if (!bw_n) begin
         lane_mask = ~lane_n;
      end else begin
         lane_mask = '0;
      end
   end

   // Lanes above the configured count never write.
   logic [LANE_CNT-1:0] lane_ok;

   assign lane_ok = (DATA_W == 36) ? 4'hf : 4'h3;
   assign wr_req   = |(lane_mask & lane_ok);
   assign start_rd = !ce_n && (!proc_addr_strobe_n_n || (!ctrl_addr_strobe_n_n && !wr_req));
   assign start_wr = !ce_n && proc_addr_strobe_n_n && !ctrl_addr_strobe_n_n && wr_req;
   assign desel    = ce_n && !ctrl_addr_strobe_n_n;
   assign cont     = ctrl_addr_strobe_n_n && (proc_addr_strobe_n_n || ce_n);

   always_comb begin
      if (sleep_req) begin
         op = SBS_OP_IDLE;
      end else if (desel) begin
         op = SBS_OP_DESEL;
      end else if (start_rd) begin
         op = SBS_OP_READ;
      end else if (start_wr) begin
         op = SBS_OP_WRITE;
      end else if (cont) begin
         op = wr_req ? SBS_OP_WRITE : SBS_OP_READ;
      end else begin
         op = SBS_OP_IDLE;
      end
   end

   // ==========================================================
   // Burst address
   // ==========================================================
   logic [ADDR_W-1:0] base_reg;
   logic [1:0]        beat_reg;
   logic              active_reg;
   logic              start;
   logic [1:0]        beat_use;
   logic [1:0]        low_bits;
   logic [ADDR_W-1:0] cur_addr;

   assign start = !sleep_req && (start_rd || start_wr);

   // A continuing cycle steps to the next beat; a suspend keeps it.
   always_comb begin
      if (start) begin
         beat_use = 2'h0;
      end else if (!step_n) begin
         beat_use = beat_reg + 2'h1;
      end else begin
         beat_use = beat_reg;
      end
   end

   always_comb begin
      if (start) begin
         low_bits = ext_addr[1:0];
         cur_addr = ext_addr;
      end else begin
         if (order_il) begin
            low_bits = base_reg[1:0] ^ beat_use;
         end else begin
            low_bits = base_reg[1:0] + beat_use;
         end
         cur_addr = {base_reg[ADDR_W-1:2], low_bits};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_reg   <= '0;
         beat_reg   <= 2'h0;
         active_reg <= 1'b0;
      end else if (op == SBS_OP_READ || op == SBS_OP_WRITE) begin
         // Dummy reads step exactly like reads; output enable is not seen here.
         if (start) begin
            base_reg <= ext_addr;
         end
         beat_reg   <= beat_use;
         active_reg <= 1'b1;
      end else if (op == SBS_OP_DESEL) begin
         active_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Memory array
   // ==========================================================
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] par_keep;

   // With parity lanes off the ninth bit of every lane is forced low.
   genvar gp;
   generate
      for (gp = 0; gp < DATA_W; gp++) begin : g_par
         assign par_keep[gp] = ((gp % LANE_W) != LANE_W-1) || !parity_lane_en_n;
      end
   endgenerate

   always_ff @(posedge pclk) begin
      for (int k = 0; k < LANE_CNT; k++) begin
         if (op == SBS_OP_WRITE && lane_mask[k] && lane_ok[k]) begin
            mem[cur_addr][k*LANE_W +: LANE_W] <=
               din[k*LANE_W +: LANE_W] & par_keep[k*LANE_W +: LANE_W];
         end
      end
   end

   // ==========================================================
   // Read pipeline and drivers
   // ==========================================================
   logic [DATA_W-1:0] dout_reg;
   logic              drive_reg;
   logic              desel_hold_reg;
   logic              wr_last_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_reg <= '0;
      end else if (op == SBS_OP_READ) begin
         dout_reg <= mem[cur_addr] & par_keep;
      end
   end

   // Dual cycle deselect lets the last read word stand one cycle longer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_reg      <= 1'b0;
         desel_hold_reg <= 1'b0;
         wr_last_reg    <= 1'b0;
      end else begin
         wr_last_reg    <= (op == SBS_OP_WRITE);
         desel_hold_reg <= (op == SBS_OP_DESEL) && !single_desel && drive_reg;
         case (op)
            SBS_OP_READ: begin
               drive_reg <= 1'b1;
            end
            SBS_OP_WRITE: begin
               drive_reg <= 1'b0;
            end
            SBS_OP_DESEL: begin
               drive_reg <= !single_desel && drive_reg && !desel_hold_reg;
            end
            SBS_OP_IDLE: begin
               drive_reg <= desel_hold_reg ? 1'b0 : (drive_reg && !sleep_req);
            end
            default: begin
               drive_reg <= 1'b0;
            end
         endcase
      end
   end

   logic [DATA_W-1:0] lane_pins;

   genvar ge;
   generate
      for (ge = 0; ge < DATA_W; ge++) begin : g_oe
         assign lane_pins[ge] = lane_ok[ge / LANE_W] && par_keep[ge];
      end
   endgenerate

   // Output enable is the raw pin: it gates drivers without any clock.
   assign dq_oe  = {DATA_W{drive_reg & ~output_en_n}} & lane_pins;
   assign dq_out = dout_reg;

   // ==========================================================
   // APB read side
   // ==========================================================
   logic [31:0] status;

   always_comb begin
      status = 32'h0;
      status[STAT_ADDR_LSB +: ADDR_W] = cur_addr;
      status[STAT_ACTIVE_BIT] = active_reg;
      status[STAT_WRITE_BIT]  = wr_last_reg;
      status[STAT_DRIVE_BIT]  = drive_reg;
      status[STAT_SLEEP_BIT]  = sleep_req;
   end

   assign pready = 1'b1;

   always_comb begin
      prdata  = 32'h0;
      pslverr = 1'b0;
      if (psel && penable) begin
         if (paddr == OFS_MODE) begin
            prdata = {28'h0, mode_reg};
         end else if (paddr == OFS_STATUS) begin
            prdata = pwrite ? 32'h0 : status;
         end else begin
            pslverr = 1'b1;
         end
      end
   end

endmodule : sbs_ctrl
`default_nettype wire
